// ===== design/timer_map.vh
// Register map, field positions, reset values and divider counts of the timer block
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// ==================================================
// Register byte offsets
`define T0_LOW_OFF 8'h00
`define T1_LOW_OFF 8'h04
`define T0_HIGH_OFF 8'h08
`define T1_HIGH_OFF 8'h0c
`define CTRL_OFF 8'h10
`define MODE_OFF 8'h14
`define SCALE_OFF 8'h18
`define IRQEN_OFF 8'h1c
`define POL_OFF 8'h20

// ==================================================
// Field positions
`define CTRL_OVF1 7
`define CTRL_RUN1 6
`define CTRL_OVF0 5
`define CTRL_RUN0 4
`define MODE_GATE_EN1 7
`define MODE_CT1 6
`define MODE_T1_HI 5
`define MODE_T1_LO 4
`define MODE_GATE_EN0 3
`define MODE_CT0 2
`define MODE_T0_HI 1
`define MODE_T0_LO 0
`define SCALE_SYS1 4
`define SCALE_SYS0 3
`define SCALE_SEL_HI 1
`define SCALE_SEL_LO 0
`define IRQEN_EN1 3
`define IRQEN_EN0 1
`define POL_IN1 1
`define POL_IN0 0

// ==================================================
// Reset values
`define BYTE_RST 8'h00
`define POL_RST 2'h0

// ==================================================
// Operating modes
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_8RELOAD 2'h2
`define MODE_SPLIT 2'h3

// ==================================================
// Prescaler divide counts (terminal values, divide minus one)
`define DIV12_LAST 6'h0b
`define DIV4_LAST 6'h03
`define DIV48_LAST 6'h2f
`define DIV8_LAST 6'h07
`define SEL_DIV12 2'h0
`define SEL_DIV4 2'h1
`define SEL_DIV48 2'h2
`define SEL_EXT8 2'h3

`endif

// ===== design/fall_detect.v
// Sampler and falling-edge detector for an external count or clock pin
module fall_detect (
	input wire pclk, // System clock
	input wire presetn, // Asynchronous reset, active low
	input wire pin, // External input level
	output reg fall_q // One-cycle pulse per high-to-low transition
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// ==================================================
	// Three-stage sampling, edge taken between later stages
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			fall_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			fall_q <= s3_q & ~s2_q; // R4 R5
		end
	end
endmodule // fall_detect

// ===== design/prescaler.v
// Shared prescaler producing one-cycle enable pulses for the timers
`include "timer_map.vh"
module prescaler (
	input wire pclk, // System clock
	input wire presetn, // Asynchronous reset, active low
	input wire [1:0] prescale_select, // Divide selection
	input wire osc_fall, // Pulse per external oscillator falling edge
	output reg tick_q // Prescaled enable pulse
);
	reg [5:0] cnt_q;
	reg [5:0] last;
	wire step;

	// ==================================================
	// Terminal count and advance condition
	always @* begin
		case (prescale_select)
			`SEL_DIV12: last = `DIV12_LAST;
			`SEL_DIV4: last = `DIV4_LAST;
			`SEL_DIV48: last = `DIV48_LAST;
			default: last = `DIV8_LAST;
		endcase
	end

	assign step = (prescale_select == `SEL_EXT8) ? osc_fall : 1'b1; // R2

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (cnt_q > last) begin
				cnt_q <= 6'h00;
			end else if (step) begin
				if (cnt_q == last) begin
					cnt_q <= 6'h00;
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 6'h01;
				end
			end
		end
	end
endmodule // prescaler

// ===== design/timer_block.v
// Dual counter/timer with APB register access
//
// Functional notes
// (R1) Timers 0 and 1 offer 13-bit, 16-bit, 8-bit reload; split mode on timer 0 only.
// (R2) Clock picked from five sources by per-timer selects and shared prescale field.
// (R3) Each timer counts either the prescaled clock or the undivided system clock.
// (R4) Counter operation increments once per falling edge on the count pin.
// (R5) Event counting works up to a quarter of system clock rate.
// (R6) The external source holds each level at least two system clocks.
// (R7) Each timer holds 16 bits read and written as low and high bytes.
// (R8) Shared control register holds run bits and reports overflow flags.
// (R9) Per-timer interrupt enable bits gate the interrupt requests.
// (R10) Shared mode register; each timer configured independently.
// (R11) In 13-bit mode the high byte holds the eight upper count bits.
// (R12) In 13-bit mode the five low count bits sit in low byte bits 4..0.
// (R13) In 13-bit mode low byte bits 7..5 are meaningless; software masks them.
// (R14) In 13-bit mode rollover from all ones sets the overflow flag.
// (R15) A set overflow flag with its enable raises that timer's interrupt.
// (R16) Timer 1 works like timer 0 with its own registers and bits.
// (R17) Count-select one counts pin falls; zero counts the selected clock.
// (R18) Counting needs run set and gate clear or gate input active.
// (R19) 16-bit mode uses all sixteen bits as the count.
// (R20) 8-bit reload mode reloads low byte from high byte on overflow, sets flag.
// (R21) A halted timer keeps its count and stays writable.
`include "timer_map.vh"
module timer_block (
	input wire pclk, // System clock
	input wire presetn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB write
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire t0_count_pin, // Timer 0 count input
	input wire t1_count_pin, // Timer 1 count input
	input wire ext_gate_in0, // Timer 0 gate input
	input wire ext_gate_in1, // Timer 1 gate input
	input wire external_osc_clock, // External oscillator, sampled
	output reg t0_irq, // Timer 0 interrupt request
	output reg t1_irq // Timer 1 interrupt request
);
	// ==================================================
	// Registers
	reg [7:0] t0_low_byte_q;
	reg [7:0] t0_high_byte_q;
	reg [7:0] t1_low_byte_q;
	reg [7:0] t1_high_byte_q;
	reg [7:0] timer_control_reg_q;
	reg [7:0] timer_mode_reg_q;
	reg [7:0] clock_scale_reg_q;
	reg [7:0] interrupt_enable_reg_q;
	reg [1:0] polarity_q;
	reg in0_lvl_q;
	reg in1_lvl_q;

	// ==================================================
	// Functions
	// One count step in modes 0..2: {overflow, high, low}
	function [16:0] count_step;
		input [1:0] mode;
		input [7:0] lo;
		input [7:0] hi;
		reg [13:0] c13;
		reg [16:0] c16;
		reg [8:0] c8;
		begin
			c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
			c16 = {1'b0, hi, lo} + 17'h00001;
			c8 = {1'b0, lo} + 9'h001;
			case (mode)
				`MODE_13BIT: begin
					count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // R11 R12 R13 R14
				end
				`MODE_16BIT: begin
					count_step = c16; // R19
				end
				`MODE_8RELOAD: begin
					count_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])}; // R20
				end
				default: begin
					count_step = {1'b0, hi, lo};
				end
			endcase
		end
	endfunction

	// Clock source pick for one timer
	function pick_source;
		input ct;
		input pin_fall;
		input sysm;
		input presc;
		begin
			if (ct) begin
				pick_source = pin_fall; // R17 R4
			end else begin
				pick_source = sysm ? 1'b1 : presc; // R3 R17
			end
		end
	endfunction

	// Run gating for one timer
	function run_ok;
		input run;
		input gate;
		input active;
		begin
			run_ok = run & (~gate | active); // R18
		end
	endfunction

	// ==================================================
	// Field decode
	wire t0_run = timer_control_reg_q[`CTRL_RUN0];
	wire t1_run = timer_control_reg_q[`CTRL_RUN1];
	wire t0_overflow_flag = timer_control_reg_q[`CTRL_OVF0];
	wire t1_overflow_flag = timer_control_reg_q[`CTRL_OVF1];
	wire t0_gate_enable = timer_mode_reg_q[`MODE_GATE_EN0];
	wire t1_gate_enable = timer_mode_reg_q[`MODE_GATE_EN1];
	wire t0_count_select = timer_mode_reg_q[`MODE_CT0];
	wire t1_count_select = timer_mode_reg_q[`MODE_CT1];
	wire [1:0] t0_mode = timer_mode_reg_q[`MODE_T0_HI:`MODE_T0_LO]; // R10
	wire [1:0] t1_mode = timer_mode_reg_q[`MODE_T1_HI:`MODE_T1_LO]; // R10
	wire t0_system_clock_select = clock_scale_reg_q[`SCALE_SYS0];
	wire t1_system_clock_select = clock_scale_reg_q[`SCALE_SYS1];
	wire [1:0] prescale_select = clock_scale_reg_q[`SCALE_SEL_HI:`SCALE_SEL_LO]; // R2
	wire t0_irq_enable = interrupt_enable_reg_q[`IRQEN_EN0];
	wire t1_irq_enable = interrupt_enable_reg_q[`IRQEN_EN1];
	wire t0_split = (t0_mode == `MODE_SPLIT); // R1

	// ==================================================
	// Pin sampling and prescaler
	wire t0_fall;
	wire t1_fall;
	wire osc_fall;
	wire presc_tick;

	fall_detect u_t0_pin (
		.pclk(pclk),
		.presetn(presetn),
		.pin(t0_count_pin),
		.fall_q(t0_fall)
	);

	fall_detect u_t1_pin (
		.pclk(pclk),
		.presetn(presetn),
		.pin(t1_count_pin),
		.fall_q(t1_fall)
	);

	fall_detect u_osc_pin (
		.pclk(pclk),
		.presetn(presetn),
		.pin(external_osc_clock),
		.fall_q(osc_fall)
	);

	prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.prescale_select(prescale_select),
		.osc_fall(osc_fall),
		.tick_q(presc_tick)
	);

	// Gate inputs active when their level matches the polarity bit
	wire act0 = (in0_lvl_q == polarity_q[`POL_IN0]);
	wire act1 = (in1_lvl_q == polarity_q[`POL_IN1]);

	// ==================================================
	// Count enables
	wire run0 = run_ok(t0_run, t0_gate_enable, act0);
	wire tick0 = run0 & pick_source(t0_count_select, t0_fall, t0_system_clock_select, presc_tick);
	// Split mode upper half: timer function only, run by timer 1 run bit
	wire t0_hi_tick = t1_run & pick_source(1'b0, 1'b0, t0_system_clock_select, presc_tick); // R1
	// Timer 1 runs on mode alone and loses its pin while timer 0 is split
	wire run1 = t0_split ? (t1_mode != `MODE_SPLIT) : (run_ok(t1_run, t1_gate_enable, act1) &
		(t1_mode != `MODE_SPLIT)); // R16 R18
	wire tick1 = run1 & pick_source(t1_count_select & ~t0_split, t1_fall, t1_system_clock_select, presc_tick);

	// ==================================================
	// Next counts
	reg [7:0] t0_nxt_lo;
	reg [7:0] t0_nxt_hi;
	reg t0_ovf;
	reg t0_hi_ovf;
	reg [7:0] t1_nxt_lo;
	reg [7:0] t1_nxt_hi;
	reg t1_ovf;

	always @* begin
		t0_nxt_lo = t0_low_byte_q;
		t0_nxt_hi = t0_high_byte_q;
		t0_ovf = 1'b0;
		t0_hi_ovf = 1'b0;
		if (t0_split) begin
			if (tick0) begin
				{t0_ovf, t0_nxt_lo} = {1'b0, t0_low_byte_q} + 9'h001; // R1
			end
			if (t0_hi_tick) begin
				{t0_hi_ovf, t0_nxt_hi} = {1'b0, t0_high_byte_q} + 9'h001; // R1
			end
		end else if (tick0) begin
			{t0_ovf, t0_nxt_hi, t0_nxt_lo} = count_step(t0_mode, t0_low_byte_q, t0_high_byte_q);
		end
	end

	always @* begin
		t1_nxt_lo = t1_low_byte_q;
		t1_nxt_hi = t1_high_byte_q;
		t1_ovf = 1'b0;
		if (tick1) begin
			{t1_ovf, t1_nxt_hi, t1_nxt_lo} = count_step(t1_mode, t1_low_byte_q, t1_high_byte_q); // R16
		end
	end

	// Timer 1 overflow cannot reach its flag while timer 0 is split
	wire set_ovf0 = t0_ovf; // R14
	wire set_ovf1 = (t1_ovf & ~t0_split) | t0_hi_ovf; // R14 R16

	// ==================================================
	// APB decode
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready & pwrite;
	wire hit_t0l = (paddr == `T0_LOW_OFF);
	wire hit_t1l = (paddr == `T1_LOW_OFF);
	wire hit_t0h = (paddr == `T0_HIGH_OFF);
	wire hit_t1h = (paddr == `T1_HIGH_OFF);
	wire hit_ctrl = (paddr == `CTRL_OFF);
	wire hit_mode = (paddr == `MODE_OFF);
	wire hit_scale = (paddr == `SCALE_OFF);
	wire hit_irqen = (paddr == `IRQEN_OFF);
	wire hit_pol = (paddr == `POL_OFF);
	wire mapped = hit_t0l | hit_t1l | hit_t0h | hit_t1h | hit_ctrl | hit_mode |
		hit_scale | hit_irqen | hit_pol;

	reg [7:0] rd_byte;

	always @* begin
		case (paddr)
			`T0_LOW_OFF: rd_byte = t0_low_byte_q; // R7 R13
			`T1_LOW_OFF: rd_byte = t1_low_byte_q; // R7
			`T0_HIGH_OFF: rd_byte = t0_high_byte_q; // R7
			`T1_HIGH_OFF: rd_byte = t1_high_byte_q; // R7
			`CTRL_OFF: rd_byte = timer_control_reg_q; // R8
			`MODE_OFF: rd_byte = timer_mode_reg_q;
			`SCALE_OFF: rd_byte = clock_scale_reg_q;
			`IRQEN_OFF: rd_byte = interrupt_enable_reg_q;
			`POL_OFF: rd_byte = {6'h00, polarity_q};
			default: rd_byte = 8'h00;
		endcase
	end

	// ==================================================
	// Bus response: ready one cycle after setup, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			if (setup) begin
				prdata <= {24'h000000, rd_byte};
			end
		end
	end

	// ==================================================
	// Count registers: a software write wins over a count in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0_low_byte_q <= `BYTE_RST;
			t0_high_byte_q <= `BYTE_RST;
			t1_low_byte_q <= `BYTE_RST;
			t1_high_byte_q <= `BYTE_RST;
		end else begin
			t0_low_byte_q <= (wr & hit_t0l) ? pwdata[7:0] : t0_nxt_lo; // R7 R21
			t0_high_byte_q <= (wr & hit_t0h) ? pwdata[7:0] : t0_nxt_hi; // R7 R21
			t1_low_byte_q <= (wr & hit_t1l) ? pwdata[7:0] : t1_nxt_lo; // R7 R21
			t1_high_byte_q <= (wr & hit_t1h) ? pwdata[7:0] : t1_nxt_hi; // R7 R21
		end
	end

	// ==================================================
	// Control register: hardware overflow set wins over a software clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg_q <= `BYTE_RST;
		end else begin
			if (wr & hit_ctrl) begin
				timer_control_reg_q <= pwdata[7:0]; // R8
			end
			if (set_ovf0) begin
				timer_control_reg_q[`CTRL_OVF0] <= 1'b1; // R14
			end
			if (set_ovf1) begin
				timer_control_reg_q[`CTRL_OVF1] <= 1'b1; // R14 R16
			end
		end
	end

	// ==================================================
	// Configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_reg_q <= `BYTE_RST;
			clock_scale_reg_q <= `BYTE_RST;
			interrupt_enable_reg_q <= `BYTE_RST;
			polarity_q <= `POL_RST;
		end else begin
			if (wr & hit_mode) begin
				timer_mode_reg_q <= pwdata[7:0]; // R10
			end
			if (wr & hit_scale) begin
				clock_scale_reg_q <= pwdata[7:0]; // R2
			end
			if (wr & hit_irqen) begin
				interrupt_enable_reg_q <= pwdata[7:0]; // R9
			end
			if (wr & hit_pol) begin
				polarity_q <= pwdata[1:0];
			end
		end
	end

	// ==================================================
	// Gate input sampling and interrupt requests
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in0_lvl_q <= 1'b0;
			in1_lvl_q <= 1'b0;
			t0_irq <= 1'b0;
			t1_irq <= 1'b0;
		end else begin
			in0_lvl_q <= ext_gate_in0;
			in1_lvl_q <= ext_gate_in1;
			t0_irq <= t0_overflow_flag & t0_irq_enable; // R9 R15
			t1_irq <= t1_overflow_flag & t1_irq_enable; // R9 R15
		end
	end
endmodule // timer_block

// ===== testbench/timer_block_asserts.sv
// Checker for bus answers and interrupt requests of the timer block
`include "timer_map.vh"
module timer_block_asserts (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire psel, // Select
	input wire penable, // Enable
	input wire pwrite, // Direction
	input wire [7:0] paddr, // Address
	input wire [31:0] pwdata, // Write data
	input wire [31:0] prdata, // Read data
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire t0_irq, // Timer 0 request
	input wire t1_irq // Timer 1 request
);
	timeunit 1ns;
	timeprecision 100ps;
	// ========================================
	// Shadow of the enable bits written by software
	reg [1:0] en_q;
	wire wr_en = psel && penable && pready && pwrite && paddr == `IRQEN_OFF;
	wire setup = psel && !penable;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_q <= 2'h0;
		else if (wr_en)
			en_q <= {pwdata[`IRQEN_EN1], pwdata[`IRQEN_EN0]};
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========================================
	// Assertions
	a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	a_err_unmapped: assert property (setup && paddr > `POL_OFF |=> pslverr && prdata == 32'h0)
		else $error("unmapped address not refused");
	a_err_mapped: assert property (setup && paddr <= `POL_OFF && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped address refused");
	a_read_high_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data bits set");
	a_t0_irq_gated: assert property (t0_irq |-> $past(en_q[0])) else $error("timer 0 request while masked");
	a_t1_irq_gated: assert property (t1_irq |-> $past(en_q[1])) else $error("timer 1 request while masked");
	a_irq_masked: assert property (wr_en && !pwdata[`IRQEN_EN1] |=> ##1 !t1_irq) else $error("mask ignored");
	c_t0_irq: cover property ($rose(t0_irq));
	c_t1_irq: cover property ($rose(t1_irq));
	c_refused: cover property (pready && pslverr);
endmodule // timer_block_asserts

bind timer_block timer_block_asserts i_timer_block_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .t0_irq(t0_irq), .t1_irq(t1_irq));

// ===== testbench/pin_model.sv
// External count, gate and oscillator pins facing the timer block
module pin_model (
	input wire pclk, // System clock
	output logic t0_count_pin, // Timer 0 count pin
	output logic t1_count_pin, // Timer 1 count pin
	output logic ext_gate_in0, // Timer 0 gate
	output logic ext_gate_in1, // Timer 1 gate
	output logic external_osc_clock // Free-running oscillator
);
	timeunit 1ns;
	timeprecision 100ps;
	int osc_cnt = 0;
	initial begin
		{t0_count_pin, t1_count_pin} = 2'h3;
		{ext_gate_in0, ext_gate_in1, external_osc_clock} = 3'h1;
	end
	// ========================================
	// Oscillator at one sixth of the system clock
	always @(posedge pclk) begin
		osc_cnt <= (osc_cnt == 2) ? 0 : osc_cnt + 1;
		if (osc_cnt == 2)
			external_osc_clock <= ~external_osc_clock;
	end
	// ========================================
	// Falls with each level held two or three clocks
	task automatic falls(input bit which, input int n);
		repeat (n) begin
			if (which) t1_count_pin <= 1'b0; else t0_count_pin <= 1'b0;
			repeat (2 + $urandom_range(1)) @(posedge pclk);
			if (which) t1_count_pin <= 1'b1; else t0_count_pin <= 1'b1;
			repeat (2 + $urandom_range(1)) @(posedge pclk);
		end
	endtask
	task automatic gate(input bit which, input bit lvl);
		if (which) ext_gate_in1 <= lvl; else ext_gate_in0 <= lvl;
	endtask
endmodule // pin_model

// ===== testbench/test_timer_block.sv
// Self-checking bench for the timer block
`include "timer_map.vh"
module test_timer_block;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, t0_irq, t1_irq, t0p, t1p, g0, g1, osc, er;
	logic [7:0] paddr, lo, hi;
	logic [31:0] pwdata, prdata, rd;
	logic [16:0] ex;
	bit [1:0] m;
	bit t, g, lv, r, pol;
	int n, err_total = 0, comparisons = 0, cyc = 0;
	timer_block i_timer_block (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .t0_count_pin(t0p),
		.t1_count_pin(t1p), .ext_gate_in0(g0), .ext_gate_in1(g1), .external_osc_clock(osc), .t0_irq(t0_irq),
		.t1_irq(t1_irq));
	pin_model i_pin_model (.pclk(pclk), .t0_count_pin(t0p), .t1_count_pin(t1p), .ext_gate_in0(g0),
		.ext_gate_in1(g1), .external_osc_clock(osc));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			$display("MISMATCH %0t timeout", $time);
			err_total++;
			results;
		end
	end
	// ========================================
	// Helpers
	task automatic results;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t value got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) chk(0, 1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count after c events in the given mode; top bit is the overflow
	function automatic logic [16:0] step(bit [1:0] md, logic [7:0] l, logic [7:0] h, int c);
		logic [12:0] s;
		logic v = 1'b0;
		repeat (c) begin
			if (md == `MODE_13BIT) begin
				s = {h, l[4:0]} + 13'h1;
				v |= s == 13'h0;
				{h, l[4:0]} = s;
			end else if (md == `MODE_16BIT) begin
				v |= {h, l} == 16'hffff;
				{h, l} = {h, l} + 16'h1;
			end else begin
				l = l + 8'h1;
				if (l == 8'h0) begin
					v = 1'b1;
					l = h;
				end
			end
		end
		return {v, h, l};
	endfunction
	// ========================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		void'($urandom(32'hc35c4f98));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 9; a++) begin
			apb(0, 8'(a * 4), 0);
			chk({er, rd[30:0]}, {a == 9, 31'h0});
		end
		for (int a = 0; a < 4; a++) begin
			lo = $urandom;
			apb(1, 8'(a * 4), lo);
			apb(0, 8'(a * 4), 0);
			chk(rd, lo);
		end
		// Four prescaler settings, then the undivided clock
		for (int s = 0; s < 5; s++) begin
			apb(1, `SCALE_OFF, s == 4 ? 32'h8 : s);
			apb(1, `MODE_OFF, 1);
			apb(1, `T0_LOW_OFF, 0);
			apb(1, `T0_HIGH_OFF, 0);
			apb(1, `CTRL_OFF, 32'h10);
			repeat (480) @(posedge pclk);
			apb(1, `CTRL_OFF, 0);
			apb(0, `T0_LOW_OFF, 0);
			lo = rd[7:0];
			apb(0, `T0_HIGH_OFF, 0);
			n = s == 4 ? 483 : 480 / (s == 1 ? 4 : s == 0 ? 12 : 48);
			chk({rd[7:0], lo} + 16'h3 - 16'(n) <= 16'h6, 1);
		end
		// Events on both timers in modes 0 to 2, random gate and run
		for (int i = 0; i < 60; i++) begin
			{t, g, lv, r, pol} = $urandom;
			m = $urandom_range(2);
			n = $urandom_range(1, 6);
			lo = $urandom;
			hi = $urandom;
			if (i % 4) {hi, lo} = {8'hff, lo | 8'hfc};
			ex = step(m, lo, hi, (r && (!g || lv == pol)) ? n : 0);
			apb(1, t ? `T1_LOW_OFF : `T0_LOW_OFF, lo);
			apb(1, t ? `T1_HIGH_OFF : `T0_HIGH_OFF, hi);
			apb(1, `MODE_OFF, 8'({g, 1'b1, m}) << (t * 4));
			apb(1, `POL_OFF, 8'(pol) << t);
			apb(1, `IRQEN_OFF, t ? 8 : 2);
			i_pin_model.gate(t, lv);
			apb(1, `CTRL_OFF, 8'(r) << (4 + t * 2));
			i_pin_model.falls(t, n);
			repeat (8) @(posedge pclk);
			apb(0, t ? `T1_LOW_OFF : `T0_LOW_OFF, 0);
			chk(rd & (m ? 8'hff : 8'h1f), ex[7:0] & (m ? 8'hff : 8'h1f));
			apb(0, t ? `T1_HIGH_OFF : `T0_HIGH_OFF, 0);
			chk(rd, ex[15:8]);
			apb(0, `CTRL_OFF, 0);
			chk(rd, 8'({ex[16], r}) << (4 + t * 2));
			chk(t ? t1_irq : t0_irq, ex[16]);
			apb(1, `IRQEN_OFF, 0);
			repeat (2) @(posedge pclk);
			chk(t ? t1_irq : t0_irq, 0);
			apb(1, `CTRL_OFF, 0);
		end
		// Split timer 0: upper byte runs on the timer 1 run bit and sets the timer 1 flag
		apb(1, `SCALE_OFF, 32'h8);
		apb(1, `MODE_OFF, `MODE_SPLIT);
		apb(1, `T0_LOW_OFF, 0);
		apb(1, `T0_HIGH_OFF, 32'hf0);
		apb(1, `IRQEN_OFF, 8);
		apb(1, `CTRL_OFF, 32'h40);
		repeat (20) @(posedge pclk);
		apb(0, `CTRL_OFF, 0);
		chk(rd, 32'hc0);
		chk(t1_irq, 1);
		apb(1, `CTRL_OFF, 0);
		apb(0, `T0_HIGH_OFF, 0);
		chk(rd, 32'h0a);
		apb(0, `T0_LOW_OFF, 0);
		chk(rd, 0);
		results;
	end
endmodule // test_timer_block
